// ==== verilog/system_clock_generation.v ====
// System clock generation: root selection, sync and agent clock outputs,
// system bus, memory, local bus and unit clock waveforms, ratio decode.
// Assumes clk_i runs as the memory controller clock (twice the system bus
// clock) and that clock pin inputs are sampled levels synchronous to clk_i.
//
// How it works
// - Host mode uses the primary input clock pin as root source.
// - Host mode drives undivided or halved root onto sync output.
// - Host mode provides three independent agent clock outputs.
// - After reset every agent clock output is held low.
// - Each agent clock toggles only once its own enable bit is set.
// - All enabled agent clock outputs are phase aligned.
// - Agent mode uses the PCI clock pin; sync and agent outputs unused.
// - System bus ratio is multiplier, doubled when input divide selected.
// - Multipliers come from the low reset word captured on the first edge after reset release.
// - Engine ratio is multiplier over one plus divider, doubled in agent mode with input divide.
// - Memory controller clock is twice bus clock; halved for memory pins.
// - Local bus controller clock is divided to form sync and clock outs.
// - Local bus out is 1/2, 1/4 or 1/8; controller clock 1x or 2x.
// - Security group full, off, half, third; PCI-DMA group off or full.
// - System multiplier codes 2 to 6 are valid, others reserved.
// - Core ratio with middle bits zero bypasses the core PLL.
`timescale 1ns/1ps
`default_nettype none
`include "system_clock_defs.vh"

module system_clock_generation
#(
    parameter AGENT_OUTPUTS = 3,
    parameter LB_OUTPUTS    = 3
)
(
    input  wire                     clk_i,
    input  wire                     reset_i,
    input  wire                     host_mode_select_i,
    input  wire                     input_divide_config_i,
    input  wire                     primary_input_clock_i,
    input  wire                     pci_clock_i,
    input  wire [`RCW_WIDTH-1:0]    reset_config_word_low_i,
    input  wire [AGENT_OUTPUTS-1:0] agent_clock_out_enable_i,
    input  wire [1:0]               local_bus_divider_field_i,
    input  wire [1:0]               security_ratio_i,
    input  wire                     pci_dma_clock_on_i,
    output reg                      sync_output_o,
    output wire [AGENT_OUTPUTS-1:0] agent_clock_o,
    output reg                      system_bus_clock_o,
    output reg                      memory_bus_clock_out_o,
    output reg                      memory_bus_clock_out_n_o,
    output reg                      local_bus_sync_output_o,
    output reg  [LB_OUTPUTS-1:0]    local_bus_clock_outputs_o,
    output wire                     security_group_clock_o,
    output wire                     pci_dma_group_clock_o,
    output reg  [3:0]               system_multiplier_o,
    output reg                      multiplier_reserved_o,
    output reg  [4:0]               system_bus_ratio_o,
    output reg  [6:0]               core_ratio_select_o,
    output reg                      core_pll_bypass_o,
    output reg  [6:0]               engine_ratio_num_o,
    output reg  [1:0]               engine_ratio_den_o,
    output reg                      config_captured_o
);

    // ****************************************
    // Reset word capture
    // ****************************************
    // The word is taken on the first edge after release, never under reset
    reg [`RCW_WIDTH-1:0] reset_config_word;

    always @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            reset_config_word <= `RCW_RESET_VALUE;
            config_captured_o <= 1'b0;
        end
        else if (!config_captured_o)
        begin
            reset_config_word <= reset_config_word_low_i;
            config_captured_o <= 1'b1;
        end
    end

    wire [3:0] spm_field  = reset_config_word[`RCW_SPM_MSB:`RCW_SPM_LSB];
    wire [6:0] core_field = reset_config_word[`RCW_CORE_MSB:`RCW_CORE_LSB];
    wire [3:0] core_mid   =
        reset_config_word[`RCW_CORE_MID_MSB:`RCW_CORE_MID_LSB];
    wire [4:0] epm_field  = reset_config_word[`RCW_EPM_MSB:`RCW_EPM_LSB];
    wire       epd_field  = reset_config_word[`RCW_EPD_BIT];
    wire       lb_mode    = reset_config_word[`RCW_LB_MODE_BIT];

    // ****************************************
    // Ratio decode
    // ****************************************
    reg        next_reserved;
    reg  [3:0] next_mult;
    reg  [4:0] next_bus_ratio;
    reg  [6:0] next_eng_num;

    always @*
    begin
        next_reserved = (spm_field < `SPM_MIN) || (spm_field > `SPM_MAX);
        next_mult = next_reserved ? 4'h0 : spm_field;
        // Bus ratio against the sync input; input divide doubles it
        if (input_divide_config_i)
            next_bus_ratio = {next_mult, 1'b0};
        else
            next_bus_ratio = {1'b0, next_mult};
        // Doubling applies only when the PCI clock pin is the root
        if (!host_mode_select_i && input_divide_config_i)
            next_eng_num = {1'b0, epm_field, 1'b0};
        else
            next_eng_num = {2'h0, epm_field};
    end

    always @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            system_multiplier_o   <= 4'h0;
            multiplier_reserved_o <= 1'b0;
            system_bus_ratio_o    <= 5'h00;
            core_ratio_select_o   <= 7'h00;
            core_pll_bypass_o     <= 1'b0;
            engine_ratio_num_o    <= 7'h00;
            engine_ratio_den_o    <= 2'h0;
        end
        else
        begin
            system_multiplier_o   <= next_mult;
            multiplier_reserved_o <= next_reserved;
            system_bus_ratio_o    <= next_bus_ratio;
            core_ratio_select_o   <= core_field;
            core_pll_bypass_o     <=
                (core_mid == `CORE_BYPASS_CODE);
            engine_ratio_num_o    <= next_eng_num;
            engine_ratio_den_o    <= {1'b0, epd_field} + 2'h1;
        end
    end

    // ****************************************
    // Root clock, halving stage and sync output
    // ****************************************
    reg  root_prev;
    reg  root_half;
    wire root_level = host_mode_select_i ? primary_input_clock_i
                                         : pci_clock_i;
    wire root_rise  = root_level & ~root_prev;
    wire next_half  = root_rise ? ~root_half : root_half;
    // Agent mode parks the sync and agent clock sources low
    wire next_agent_src = host_mode_select_i &
        (input_divide_config_i ? next_half : root_level);

    always @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            root_prev     <= 1'b0;
            root_half     <= 1'b0;
            sync_output_o <= 1'b0;
        end
        else
        begin
            root_prev     <= root_level;
            root_half     <= next_half;
            sync_output_o <= next_agent_src;
        end
    end

    // ****************************************
    // Agent clock outputs
    // ****************************************
    // One shared source value keeps every output on the same edge
    genvar g;
    generate
        for (g = 0; g < AGENT_OUTPUTS; g = g + 1)
        begin : agent_out
            clock_gate_cell u_gate
            (
                .clk_i        (clk_i),
                .reset_i      (reset_i),
                .src_next_i   (next_agent_src),
                .enable_req_i (agent_clock_out_enable_i[g]),
                .gated_o      (agent_clock_o[g])
            );
        end
    endgenerate

    // ****************************************
    // System bus and memory clocks
    // ****************************************
    // clk_i is the memory controller clock, so the bus clock is clk_i / 2
    reg bus_phase;

    always @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            bus_phase                <= 1'b0;
            system_bus_clock_o       <= 1'b0;
            memory_bus_clock_out_o   <= 1'b0;
            memory_bus_clock_out_n_o <= 1'b1;
        end
        else
        begin
            bus_phase                <= ~bus_phase;
            system_bus_clock_o       <= ~bus_phase;
            memory_bus_clock_out_o   <= ~bus_phase;
            memory_bus_clock_out_n_o <= bus_phase;
        end
    end

    // ****************************************
    // Local bus clocks
    // ****************************************
    // Controller clock ticks every clk_i in 2x mode, every other in 1x
    reg  [2:0] lb_count;
    reg        lb_out_bit;
    wire       lb_tick = lb_mode | bus_phase;
    wire [2:0] next_lb_count = lb_tick ? lb_count + 3'h1 : lb_count;

    always @*
    begin
        case (local_bus_divider_field_i)
            `LB_DIV_BY4: lb_out_bit = next_lb_count[1];
            `LB_DIV_BY8: lb_out_bit = next_lb_count[2];
            default:     lb_out_bit = next_lb_count[0];
        endcase
    end

    always @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            lb_count                  <= 3'h0;
            local_bus_sync_output_o   <= 1'b0;
            local_bus_clock_outputs_o <= {LB_OUTPUTS{1'b0}};
        end
        else
        begin
            lb_count                  <= next_lb_count;
            local_bus_sync_output_o   <= lb_out_bit;
            local_bus_clock_outputs_o <= {LB_OUTPUTS{lb_out_bit}};
        end
    end

    // ****************************************
    // Unit group clocks
    // ****************************************
    // A new ratio is taken only at the end of a period, while the wave is low
    reg  [1:0] unit_ratio;
    reg  [2:0] unit_count;
    reg  [2:0] unit_period;
    wire [2:0] next_unit_count;
    wire       unit_wrap = (unit_count == unit_period - 3'h1);

    always @*
    begin
        case (unit_ratio)
            `UNIT_HALF:  unit_period = `PER_HALF;
            `UNIT_THIRD: unit_period = `PER_THIRD;
            default:     unit_period = `PER_FULL;
        endcase
    end

    assign next_unit_count = unit_wrap ? 3'h0 : unit_count + 3'h1;
    wire next_unit_wave = (next_unit_count < {1'b0, unit_period[2:1]});

    always @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            unit_ratio <= `UNIT_FULL;
            unit_count <= 3'h0;
        end
        else
        begin
            unit_count <= next_unit_count;
            if (unit_wrap)
                unit_ratio <= security_ratio_i;
        end
    end

    clock_gate_cell u_security_gate
    (
        .clk_i        (clk_i),
        .reset_i      (reset_i),
        .src_next_i   (next_unit_wave),
        .enable_req_i (security_ratio_i != `UNIT_OFF),
        .gated_o      (security_group_clock_o)
    );

    // Off or full system bus clock only
    clock_gate_cell u_pci_dma_gate
    (
        .clk_i        (clk_i),
        .reset_i      (reset_i),
        .src_next_i   (~bus_phase),
        .enable_req_i (pci_dma_clock_on_i),
        .gated_o      (pci_dma_group_clock_o)
    );

endmodule // system_clock_generation

`default_nettype wire

// ==== verilog/system_clock_defs.vh ====
// Constants for the system clock generation block.
// Assumes a 32-bit reset configuration word sampled after reset release.
`ifndef SYSTEM_CLOCK_DEFS_VH
`define SYSTEM_CLOCK_DEFS_VH

// ****************************************
// Reset configuration word low layout
// ****************************************
`define RCW_WIDTH          32
`define RCW_LB_MODE_BIT    0
`define RCW_SPM_LSB        4
`define RCW_SPM_MSB        7
`define RCW_CORE_LSB       8
`define RCW_CORE_MSB       14
`define RCW_CORE_MID_LSB   9
`define RCW_CORE_MID_MSB   12
`define RCW_EPM_LSB        16
`define RCW_EPM_MSB        20
`define RCW_EPD_BIT        24
`define RCW_RESET_VALUE    32'h0000_0000

// ****************************************
// Multiplier decode
// ****************************************
`define SPM_MIN            4'h2
`define SPM_MAX            4'h6
`define CORE_BYPASS_CODE   4'h0

// ****************************************
// Local bus divider field codes
// ****************************************
`define LB_DIV_BY2         2'h1
`define LB_DIV_BY4         2'h2
`define LB_DIV_BY8         2'h3

// ****************************************
// Unit group ratio codes
// ****************************************
`define UNIT_FULL          2'h0
`define UNIT_HALF          2'h1
`define UNIT_THIRD         2'h2
`define UNIT_OFF           2'h3

// Periods in clk_i cycles; clk_i stands for the memory controller clock
`define PER_FULL           3'h2
`define PER_HALF           3'h4
`define PER_THIRD          3'h6

`endif

// ==== verilog/clock_gate_cell.v ====
// One glitch-free gated clock output.
// Assumes src_next is the source waveform's next value, shared by siblings.
`timescale 1ns/1ps
`default_nettype none

module clock_gate_cell
(
    input  wire clk_i,
    input  wire reset_i,
    input  wire src_next_i,
    input  wire enable_req_i,
    output reg  gated_o
);

    reg enabled;

    // Enable only changes while the source sits low, so no runt pulse
    always @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            enabled <= 1'b0;
            gated_o <= 1'b0;
        end
        else
        begin
            if (!src_next_i)
                enabled <= enable_req_i;
            gated_o <= src_next_i & enabled;
        end
    end

endmodule // clock_gate_cell

`default_nettype wire

// ==== verification/agent_clock_receiver.sv ====
// Far-side agents: count rising edges of the clocks they receive.
// Assumes clear_i changes away from the rising edge of clk_i.
`timescale 1ns/1ps
`default_nettype none

module agent_clock_receiver
#(
    parameter W = 4
)
(
    input  wire logic              clk_i,
    input  wire logic              clear_i,
    input  wire logic [W-1:0]      clock_i,
    output var  logic [W-1:0][7:0] rises_o
);
    logic [W-1:0] last;

    // Sampling on clk_i is exact since every output is launched from it
    always @(posedge clk_i)
    begin
        last <= clock_i;
        for (int i = 0; i < W; i++)
            if (clear_i)
                rises_o[i] <= 8'h00;
            else if (clock_i[i] && !last[i])
                rises_o[i] <= rises_o[i] + 8'h01;
    end
endmodule // agent_clock_receiver

`default_nettype wire

// ==== verification/system_clock_generation_sva.sv ====
// Checker on the ports of the system clock block.
// Assumes a single clock domain with asynchronous high reset.
`timescale 1ns/1ps
`default_nettype none

module system_clock_generation_sva
#(
    parameter AGENT_OUTPUTS = 3,
    parameter LB_OUTPUTS    = 3
)
(
    input wire logic                     clk_i,
    input wire logic                     reset_i,
    input wire logic                     host_mode_select_i,
    input wire logic                     input_divide_config_i,
    input wire logic                     primary_input_clock_i,
    input wire logic [AGENT_OUTPUTS-1:0] agent_clock_out_enable_i,
    input wire logic                     sync_output_o,
    input wire logic [AGENT_OUTPUTS-1:0] agent_clock_o,
    input wire logic                     system_bus_clock_o,
    input wire logic                     memory_bus_clock_out_o,
    input wire logic                     memory_bus_clock_out_n_o,
    input wire logic                     local_bus_sync_output_o,
    input wire logic [LB_OUTPUTS-1:0]    local_bus_clock_outputs_o,
    input wire logic [3:0]               system_multiplier_o,
    input wire logic                     multiplier_reserved_o,
    input wire logic [4:0]               system_bus_ratio_o,
    input wire logic [6:0]               core_ratio_select_o,
    input wire logic                     core_pll_bypass_o,
    input wire logic [1:0]               engine_ratio_den_o
);
    // Decode outputs are only trusted once this saturates
    logic [1:0] up;
    always_ff @(posedge clk_i or posedge reset_i)
        if (reset_i)
            up <= 2'h0;
        else if (up != 2'h3)
            up <= up + 2'h1;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    AST_IDLE_0: assert property ((!agent_clock_out_enable_i[0])[*3]
        ##0 !agent_clock_o[0] |=> !agent_clock_o[0])
        else $error("agent clock 0 rose while disabled");
    AST_IDLE_2: assert property ((!agent_clock_out_enable_i[2])[*3]
        ##0 !agent_clock_o[2] |=> !agent_clock_o[2])
        else $error("agent clock 2 rose while disabled");
    AST_ALIGN_RISE: assert property (host_mode_select_i &&
        |(agent_clock_o & ~$past(agent_clock_o)) |-> $rose(sync_output_o))
        else $error("agent clock rise out of phase");
    AST_ALIGN_FALL: assert property (host_mode_select_i &&
        |(~agent_clock_o & $past(agent_clock_o)) |-> $fell(sync_output_o))
        else $error("agent clock fall out of phase");
    AST_AGENT_SYNC: assert property ((!host_mode_select_i)[*2]
        |-> !sync_output_o)
        else $error("sync output active in agent mode");
    AST_SYNC_RISE: assert property ((host_mode_select_i &&
        !input_divide_config_i)[*3] ##0 $rose(primary_input_clock_i)
        |-> ##[1:2] sync_output_o)
        else $error("sync output missed a root rise");
    AST_BUS_TOGGLE: assert property (up == 2'h3 |->
        system_bus_clock_o != $past(system_bus_clock_o))
        else $error("bus clock did not toggle");
    AST_MEM_PAIR: assert property (up == 2'h3 |->
        $changed(memory_bus_clock_out_o) &&
        memory_bus_clock_out_n_o == !memory_bus_clock_out_o)
        else $error("memory clock pair wrong");
    AST_LB_SAME: assert property (local_bus_clock_outputs_o ==
        {LB_OUTPUTS{local_bus_sync_output_o}})
        else $error("local bus clocks differ");
    AST_RESERVED: assert property (up == 2'h3 |->
        multiplier_reserved_o == (system_multiplier_o == 4'h0) &&
        (multiplier_reserved_o || (system_multiplier_o >= 4'h2 &&
        system_multiplier_o <= 4'h6)))
        else $error("reserved flag disagrees with multiplier");
    AST_RATIO: assert property (up == 2'h3 &&
        $stable(input_divide_config_i) |-> system_bus_ratio_o ==
        (input_divide_config_i ? {system_multiplier_o, 1'b0} :
        {1'b0, system_multiplier_o}))
        else $error("bus ratio wrong");
    AST_BYPASS: assert property (up == 2'h3 |->
        core_pll_bypass_o == (core_ratio_select_o[4:1] == 4'h0))
        else $error("core bypass wrong");
    AST_HELD: assert property (up == 2'h3 |->
        $stable(core_ratio_select_o) && $stable(engine_ratio_den_o))
        else $error("captured word changed");

    cover property ($rose(agent_clock_o[1]));
    cover property (up == 2'h3 && multiplier_reserved_o);
    cover property (up == 2'h3 && core_pll_bypass_o);
endmodule // system_clock_generation_sva

bind system_clock_generation system_clock_generation_sva #(
    .AGENT_OUTPUTS(AGENT_OUTPUTS), .LB_OUTPUTS(LB_OUTPUTS)) u_sva (
    .clk_i, .reset_i, .host_mode_select_i, .input_divide_config_i,
    .primary_input_clock_i, .agent_clock_out_enable_i, .sync_output_o,
    .agent_clock_o, .system_bus_clock_o, .memory_bus_clock_out_o,
    .memory_bus_clock_out_n_o, .local_bus_sync_output_o,
    .local_bus_clock_outputs_o, .system_multiplier_o,
    .multiplier_reserved_o, .system_bus_ratio_o, .core_ratio_select_o,
    .core_pll_bypass_o, .engine_ratio_den_o);

`default_nettype wire

// ==== verification/system_clock_generation_tb.sv ====
// Bench for the system clock block: counts edges over fixed windows.
// Assumes the receiver model and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none

module system_clock_generation_tb;
    logic        clk_i = 1'b0;
    logic        reset_i = 1'b1;
    logic        host_mode_select_i, input_divide_config_i, clear;
    logic        primary_input_clock_i, pci_clock_i, pci_dma_clock_on_i;
    logic [31:0] reset_config_word_low_i, w;
    logic [2:0]  agent_clock_out_enable_i, agent_clock_o;
    logic [2:0]  local_bus_clock_outputs_o;
    logic [1:0]  local_bus_divider_field_i, security_ratio_i;
    logic        sync_output_o, system_bus_clock_o, memory_bus_clock_out_o;
    logic        memory_bus_clock_out_n_o, local_bus_sync_output_o;
    logic        security_group_clock_o, pci_dma_group_clock_o;
    logic [3:0]  system_multiplier_o;
    logic        multiplier_reserved_o, core_pll_bypass_o, config_captured_o;
    logic [4:0]  system_bus_ratio_o;
    logic [6:0]  core_ratio_select_o, engine_ratio_num_o;
    logic [1:0]  engine_ratio_den_o;
    logic [3:0][7:0] pci_rises;
    logic [2:0][7:0] unit_rises;
    int          fails = 0, n_compared = 0, cyc = 0, ph = 0;

    system_clock_generation u_dut (.clk_i, .reset_i, .host_mode_select_i,
        .input_divide_config_i, .primary_input_clock_i, .pci_clock_i,
        .reset_config_word_low_i, .agent_clock_out_enable_i,
        .local_bus_divider_field_i, .security_ratio_i, .pci_dma_clock_on_i,
        .sync_output_o, .agent_clock_o, .system_bus_clock_o,
        .memory_bus_clock_out_o, .memory_bus_clock_out_n_o,
        .local_bus_sync_output_o, .local_bus_clock_outputs_o,
        .security_group_clock_o, .pci_dma_group_clock_o,
        .system_multiplier_o, .multiplier_reserved_o, .system_bus_ratio_o,
        .core_ratio_select_o, .core_pll_bypass_o, .engine_ratio_num_o,
        .engine_ratio_den_o, .config_captured_o);
    agent_clock_receiver #(.W(4)) u_pci (.clk_i, .clear_i(clear),
        .clock_i({sync_output_o, agent_clock_o}), .rises_o(pci_rises));
    agent_clock_receiver #(.W(3)) u_unit (.clk_i, .clear_i(clear),
        .clock_i({local_bus_sync_output_o, security_group_clock_o,
        pci_dma_group_clock_o}), .rises_o(unit_rises));

    // A 200 MHz memory clock keeps the bus clock at 100 MHz
    always #2.5 clk_i = ~clk_i;

    // Root period of six cycles keeps the pin far below its limit
    always @(negedge clk_i)
    begin
        ph = (ph + 1) % 6;
        primary_input_clock_i <= host_mode_select_i && ph < 3;
        pci_clock_i <= !host_mode_select_i && ph < 3;
    end

    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            fails++;
            wrap_up();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h",
                $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Window of 48 cycles holds whole periods of every expected wave
    task automatic run_and_check();
        int sr, lbp, m, e;
        repeat (24) @(negedge clk_i);
        clear = 1'b1;
        @(negedge clk_i);
        clear = 1'b0;
        repeat (48) @(negedge clk_i);
        sr = host_mode_select_i ? (input_divide_config_i ? 4 : 8) : 0;
        lbp = (local_bus_divider_field_i == 2'h3) ? 8 :
            (local_bus_divider_field_i == 2'h2) ? 4 : 2;
        lbp = w[0] ? lbp : 2 * lbp;
        m = (w[7:4] >= 2 && w[7:4] <= 6) ? w[7:4] : 0;
        check(pci_rises[3], 8'(sr));
        // Agent mode expects all three outputs parked low as well
        for (int i = 0; i < 3; i++)
        begin
            e = agent_clock_out_enable_i[i] ? sr : 0;
            check(pci_rises[i], 8'(e));
        end
        check(unit_rises[2], 8'(48 / lbp));
        e = (security_ratio_i == 2'h3) ? 0 : 24 / (security_ratio_i + 1);
        check(unit_rises[1], 8'(e));
        check(unit_rises[0], pci_dma_clock_on_i ? 8'h18 : 8'h00);
        check(8'(config_captured_o), 8'h01);
        check(8'(system_multiplier_o), 8'(m));
        check(8'(multiplier_reserved_o), 8'(m == 0));
        e = input_divide_config_i ? 2 * m : m;
        check(8'(system_bus_ratio_o), 8'(e));
        check(8'(core_ratio_select_o), 8'(w[14:8]));
        check(8'(core_pll_bypass_o), 8'(w[12:9] == 4'h0));
        e = (!host_mode_select_i && input_divide_config_i) ? 2 * w[20:16] :
            w[20:16];
        check(8'(engine_ratio_num_o), 8'(e));
        check(8'(engine_ratio_den_o), 8'(1 + w[24]));
    endtask

    initial
    begin
        int seed;
        {host_mode_select_i, input_divide_config_i, pci_dma_clock_on_i} = 3'h0;
        {primary_input_clock_i, pci_clock_i, clear} = 3'h0;
        {local_bus_divider_field_i, security_ratio_i} = 4'h0;
        agent_clock_out_enable_i = 3'h0;
        reset_config_word_low_i = 32'h0;
        w = 32'h0;
        seed = $urandom(32'h658BB278);
        for (int i = 0; i < 16; i++)
        begin
            w = $urandom();
            w[7:4] = i[3:0];
            reset_i = 1'b1;
            reset_config_word_low_i = w;
            host_mode_select_i = (i % 3) != 0;
            input_divide_config_i = 1'($urandom());
            agent_clock_out_enable_i = 3'($urandom());
            pci_dma_clock_on_i = 1'($urandom());
            local_bus_divider_field_i = i[1:0];
            security_ratio_i = i[3:2];
            repeat (4) @(negedge clk_i);
            reset_i = 1'b0;
            @(negedge clk_i);
            reset_config_word_low_i = $urandom();
            run_and_check();
            agent_clock_out_enable_i = ~agent_clock_out_enable_i;
            security_ratio_i = ~security_ratio_i;
            pci_dma_clock_on_i = ~pci_dma_clock_on_i;
            run_and_check();
        end
        wrap_up();
    end
endmodule // system_clock_generation_tb

`default_nettype wire
